// ==== far_pkg.sv ====
// constants and carrier types for the fault annunciator block
// assumes a single 250 MHz clock domain; nothing else
package far_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned FLASH_HALF_MS    = 500;
  localparam int unsigned FLASH_HALF_CYC   = FLASH_HALF_MS * 1000 * CLK_MHZ;
  localparam int unsigned PWM_BITS         = 8;
  localparam logic [7:0]  EXC_MAX_PCT      = 8'h3c;
  localparam logic [7:0]  GOV_MAX_PCT      = 8'h5a;
  localparam logic [7:0]  GOV_TYP_PCT      = 8'h1e;
  localparam logic [7:0]  PCT_FULL         = 8'h64;
  localparam int unsigned SUPPLY_BITS      = 12;
  localparam logic [11:0] DISC_THRESH_VRMS = 12'h069;
  localparam int unsigned NUM_FAULTS       = 16;
  localparam int unsigned ESTOP_BIT        = 0;
  localparam logic [9:0]  ESTOP_CODE       = 10'h066;
  localparam int unsigned DISP_LINES       = 2;
  localparam int unsigned DISP_CHARS       = 16;

  // register map
  localparam logic [3:0] ADR_STATUS  = 4'h0;
  localparam logic [3:0] ADR_MASK    = 4'h1;
  localparam logic [3:0] ADR_FAULTS  = 4'h2;
  localparam logic [3:0] ADR_PWM     = 4'h3;
  localparam logic [3:0] ADR_DISP    = 4'h4;
  localparam logic [3:0] ADR_STATE   = 4'h5;
  localparam logic [3:0] ADR_THRESH  = 4'h6;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // interrupt status bits
  localparam int unsigned IRQ_WARN   = 0;
  localparam int unsigned IRQ_SHUT   = 1;
  localparam int unsigned IRQ_CLEAR  = 2;
  localparam int unsigned IRQ_DISC   = 3;
  localparam int unsigned IRQ_BITS   = 4;
  localparam logic [3:0]  MASK_RST   = 4'h0;

  typedef enum logic [2:0] {
    MODE_OFF  = 3'b001,
    MODE_RUN  = 3'b010,
    MODE_AUTO = 3'b100
  } far_mode_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } far_bus_type;

  typedef struct packed {
    logic non_auto;
    logic warning;
    logic shutdown;
  } far_lamps_type;

endpackage : far_pkg

// ==== far_pwm_limit.sv ====
// clamps a requested duty and generates the pwm waveform
// assumes far_pkg; period of 100 steps of the clock enable
`timescale 1ns/1ps
module far_pwm_limit #(
  parameter logic [7:0] MAX_PCT = far_pkg::EXC_MAX_PCT
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic [7:0] duty_req,
  output logic      [7:0] duty_ff,
  output logic            pwm_ff
);
  logic [7:0] step_ff;
  logic [7:0] nxt_duty;

  assign nxt_duty = (duty_req > MAX_PCT) ? MAX_PCT : duty_req;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      step_ff <= 8'h00;
      duty_ff <= 8'h00;
    end else if (clk_en) begin
      if (step_ff == far_pkg::PCT_FULL - 8'h01) begin
        step_ff <= 8'h00;
        duty_ff <= nxt_duty;
      end else begin
        step_ff <= step_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_ff <= 1'b0;
    end else if (clk_en) begin
      pwm_ff <= (step_ff < duty_ff);
    end
  end

  AST_DUTY_LIMIT: assert property (@(posedge sys_clk) disable iff (!nrst)
    duty_ff <= MAX_PCT) else $error("pwm duty above its limit");

endmodule : far_pwm_limit

// ==== far_annunciator.sv ====
// fault annunciator and reset logic with lamps, display, pwm limits
// assumes synchronous panel inputs and a single-cycle register port
`timescale 1ns/1ps
module far_annunciator #(
  parameter int unsigned NF        = far_pkg::NUM_FAULTS,
  parameter int unsigned FLASH_CYC = far_pkg::FLASH_HALF_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic                clk_en,
  input  wire far_pkg::far_bus_type bus,
  output logic              [31:0] rdata_ff,
  input  wire logic          [2:0] mode_sel,
  input  wire logic                panel_reset,
  input  wire logic                remote_reset,
  input  wire logic                remote_start,
  input  wire logic                sleep_req,
  input  wire logic       [NF-1:0] warn_cond,
  input  wire logic       [NF-1:0] shut_cond,
  input  wire logic         [11:0] permanent_magnet_supply,
  output far_pkg::far_lamps_type   lamps_ff,
  output logic                     engine_run_ff,
  output logic                     breaker_trip_ff,
  output logic                     standby_ff,
  output logic                     start_disconnect_indicator_ff,
  output logic                     exc_pwm_ff,
  output logic                     gov_pwm_ff,
  output logic               [7:0] duty_cycle_indicator_ff,
  output logic               [7:0] disp_char_ff,
  output logic               [4:0] disp_pos_ff,
  output logic                     disp_we_ff,
  output logic                     irq_ff
);
  localparam int unsigned DCELLS = far_pkg::DISP_LINES * far_pkg::DISP_CHARS;

  logic [NF-1:0]    warn_lat_ff;
  logic [NF-1:0]    shut_lat_ff;
  logic             rr_q_ff;
  logic             start_seen_ff;
  logic [31:0]      flash_cnt_ff;
  logic             flash_ff;
  logic [3:0]       stat_ff;
  logic [3:0]       mask_ff;
  logic [7:0]       exc_req_ff;
  logic [7:0]       gov_req_ff;
  logic [11:0]      thresh_ff;
  logic [7:0]       disp_mem [DCELLS];
  logic [4:0]       scan_ff;
  logic [7:0]       exc_duty;
  logic [7:0]       gov_duty;
  logic             remote_cycle;
  logic             local_ok;
  logic             remote_ok;
  logic             warn_clr;
  logic             any_fault;
  logic [NF-1:0]    shut_clr_mask;
  logic [NF-1:0]    nxt_shut;
  logic             prev_shut_any_ff;
  logic             prev_warn_any_ff;

  function automatic logic is_mode(input logic [2:0] m, input far_pkg::far_mode_type t);
    return m == t;
  endfunction : is_mode

  // remote reset cycle: falling edge after an asserted level
  assign remote_cycle = rr_q_ff && !remote_reset;
  assign local_ok     = panel_reset;
  assign remote_ok    = is_mode(mode_sel, far_pkg::MODE_AUTO) && remote_cycle;
  assign warn_clr     = local_ok || remote_ok;
  assign any_fault    = (|warn_lat_ff) || (|shut_lat_ff);

  // shutdown clear mask: estop excluded for remote reset
  always_comb begin
    shut_clr_mask = '0;
    if (local_ok && is_mode(mode_sel, far_pkg::MODE_OFF)) begin
      shut_clr_mask = '1;
    end else if (remote_ok && start_seen_ff) begin
      shut_clr_mask = '1;
      shut_clr_mask[far_pkg::ESTOP_BIT] = 1'b0;
    end
  end

  // active conditions never clear: clear only applies once corrected
  assign nxt_shut = shut_cond | (shut_lat_ff & ~(shut_clr_mask & ~shut_cond));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rr_q_ff       <= 1'b0;
      start_seen_ff <= 1'b0;
    end else if (clk_en) begin
      rr_q_ff <= remote_reset;
      // remote start must be removed before the reset cycle
      if (remote_start) begin
        start_seen_ff <= 1'b0;
      end else if (!rr_q_ff && !remote_reset) begin
        start_seen_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      warn_lat_ff <= '0;
      shut_lat_ff <= '0;
    end else if (clk_en) begin
      warn_lat_ff <= warn_cond | (warn_lat_ff & ~({NF{warn_clr}} & ~warn_cond));
      shut_lat_ff <= nxt_shut;
    end
  end

  // lamps and outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flash_cnt_ff <= 32'h0000_0000;
      flash_ff     <= 1'b0;
    end else if (clk_en) begin
      if (flash_cnt_ff >= 32'(FLASH_CYC - 1)) begin
        flash_cnt_ff <= 32'h0000_0000;
        flash_ff     <= !flash_ff;
      end else begin
        flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lamps_ff        <= '0;
      engine_run_ff   <= 1'b0;
      breaker_trip_ff <= 1'b0;
      standby_ff      <= 1'b0;
    end else if (clk_en) begin
      lamps_ff.non_auto <= is_mode(mode_sel, far_pkg::MODE_OFF) && flash_ff;
      lamps_ff.warning  <= |warn_lat_ff;
      lamps_ff.shutdown <= |shut_lat_ff;
      engine_run_ff     <= !(|shut_lat_ff) && !is_mode(mode_sel, far_pkg::MODE_OFF);
      breaker_trip_ff   <= |shut_lat_ff;
      standby_ff        <= sleep_req && !any_fault;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      start_disconnect_indicator_ff <= 1'b0;
    end else if (clk_en) begin
      start_disconnect_indicator_ff <= permanent_magnet_supply > thresh_ff;
    end
  end

  // pwm stages with duty clamp
  far_pwm_limit #(.MAX_PCT(far_pkg::EXC_MAX_PCT)) u_exc (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .duty_req(exc_req_ff),
    .duty_ff (exc_duty),
    .pwm_ff  (exc_pwm_ff)
  );

  far_pwm_limit #(.MAX_PCT(far_pkg::GOV_MAX_PCT)) u_gov (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .duty_req(gov_req_ff),
    .duty_ff (gov_duty),
    .pwm_ff  (gov_pwm_ff)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      duty_cycle_indicator_ff <= 8'h00;
    end else if (clk_en) begin
      duty_cycle_indicator_ff <= exc_duty;
    end
  end

  // display: 2 x 16 character cells scanned out one per cycle
  always_ff @(posedge sys_clk) begin
    if (clk_en && bus.wr && bus.addr == far_pkg::ADR_DISP) begin
      disp_mem[bus.wdata[12:8]] <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scan_ff      <= 5'h00;
      disp_pos_ff  <= 5'h00;
      disp_char_ff <= 8'h00;
      disp_we_ff   <= 1'b0;
    end else if (clk_en) begin
      scan_ff      <= (scan_ff == 5'(DCELLS - 1)) ? 5'h00 : scan_ff + 5'h01;
      disp_pos_ff  <= scan_ff;
      disp_char_ff <= disp_mem[scan_ff];
      disp_we_ff   <= 1'b1;
    end
  end

  // register writes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mask_ff    <= far_pkg::MASK_RST;
      exc_req_ff <= 8'h00;
      gov_req_ff <= far_pkg::GOV_TYP_PCT;
      thresh_ff  <= far_pkg::DISC_THRESH_VRMS;
    end else if (clk_en && bus.wr) begin
      case (bus.addr)
        far_pkg::ADR_MASK: begin
          mask_ff <= bus.wdata[3:0];
        end
        far_pkg::ADR_PWM: begin
          exc_req_ff <= bus.wdata[7:0];
          gov_req_ff <= bus.wdata[15:8];
        end
        far_pkg::ADR_THRESH: begin
          thresh_ff <= bus.wdata[11:0];
        end
        default: begin
        end
      endcase
    end
  end

  // interrupt status: set wins over write-one-to-clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stat_ff          <= 4'h0;
      prev_shut_any_ff <= 1'b0;
      prev_warn_any_ff <= 1'b0;
    end else if (clk_en) begin
      logic [3:0] set_v;
      logic [3:0] clr_v;
      set_v = 4'h0;
      clr_v = 4'h0;
      set_v[far_pkg::IRQ_WARN]  = (|warn_lat_ff) && !prev_warn_any_ff;
      set_v[far_pkg::IRQ_SHUT]  = (|shut_lat_ff) && !prev_shut_any_ff;
      set_v[far_pkg::IRQ_CLEAR] = prev_shut_any_ff && !(|shut_lat_ff);
      set_v[far_pkg::IRQ_DISC]  = (permanent_magnet_supply > thresh_ff)
                                  && !start_disconnect_indicator_ff;
      if (bus.wr && bus.addr == far_pkg::ADR_STATUS) begin
        clr_v = bus.wdata[3:0];
      end
      stat_ff          <= (stat_ff & ~clr_v) | set_v;
      prev_shut_any_ff <= |shut_lat_ff;
      prev_warn_any_ff <= |warn_lat_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // register reads, data in the following cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_ff <= far_pkg::RD_UNMAPPED;
      if (bus.rd) begin
        case (bus.addr)
          far_pkg::ADR_STATUS: rdata_ff <= {28'h0, stat_ff};
          far_pkg::ADR_MASK:   rdata_ff <= {28'h0, mask_ff};
          far_pkg::ADR_FAULTS: rdata_ff <= {shut_lat_ff, warn_lat_ff};
          far_pkg::ADR_PWM:    rdata_ff <= {gov_duty, exc_duty, gov_req_ff, exc_req_ff};
          far_pkg::ADR_STATE:  rdata_ff <= {27'h0, standby_ff, start_seen_ff,
                                            breaker_trip_ff, lamps_ff.shutdown,
                                            lamps_ff.warning};
          far_pkg::ADR_THRESH: rdata_ff <= {20'h0, thresh_ff};
          default:             rdata_ff <= far_pkg::RD_UNMAPPED;
        endcase
      end
    end
  end

  sequence s_shut_active;
    |shut_lat_ff;
  endsequence

  sequence s_remote_cycle;
    rr_q_ff && !remote_reset;
  endsequence

  // latch follows one cycle after the condition, lamp one more
  AST_WARN_LAMP: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && (|warn_cond) ##1 clk_en |=> lamps_ff.warning)
    else $error("warning lamp not lit");

  AST_SHUT_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_shut_active and (clk_en && !panel_reset && !remote_reset && !rr_q_ff)
    |=> |shut_lat_ff) else $error("shutdown latch dropped");

  AST_LOCAL_NEEDS_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_shut_active and (clk_en && panel_reset && !is_mode(mode_sel, far_pkg::MODE_OFF)
    && !remote_ok) |=> shut_lat_ff == ($past(shut_lat_ff) | $past(shut_cond)))
    else $error("shutdown cleared outside off");

  AST_ESTOP_REMOTE: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && shut_lat_ff[far_pkg::ESTOP_BIT] && !panel_reset
    |=> shut_lat_ff[far_pkg::ESTOP_BIT]) else $error("estop cleared remotely");

  AST_REMOTE_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_remote_cycle and (clk_en && is_mode(mode_sel, far_pkg::MODE_AUTO) && start_seen_ff
    && !(|shut_cond) && !shut_lat_ff[far_pkg::ESTOP_BIT]) |=> !(|shut_lat_ff))
    else $error("remote reset failed to clear");

  AST_NO_SLEEP: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && any_fault |=> !standby_ff) else $error("standby with faults");

  AST_TRIP: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_shut_active and clk_en |=> breaker_trip_ff && !engine_run_ff)
    else $error("shutdown did not trip");

  AST_DISC: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && permanent_magnet_supply > thresh_ff |=> start_disconnect_indicator_ff)
    else $error("start disconnect missing");

  AST_NONAUTO_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !is_mode(mode_sel, far_pkg::MODE_OFF) |=> !lamps_ff.non_auto)
    else $error("non-auto lamp outside off");

endmodule : far_annunciator

// ==== far_panel_model.sv ====
// operator switch and remote contact model for the annunciator
// assumes far_pkg and a free-running sys_clk from the bench
`timescale 1ns/1ps
module far_panel_model (
  input  wire logic sys_clk,
  output logic [2:0] mode_sel,
  output logic       panel_reset,
  output logic       remote_reset,
  output logic       remote_start
);
  initial begin
    mode_sel     = far_pkg::MODE_RUN;
    panel_reset  = 1'b0;
    remote_reset = 1'b0;
    remote_start = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : hold
  task automatic set_inputs(input logic [2:0] m, input logic st, input logic rr);
    @(posedge sys_clk);
    mode_sel     <= m;
    remote_start <= st;
    remote_reset <= rr;
    hold(1);
  endtask : set_inputs
  task automatic press();
    @(posedge sys_clk);
    panel_reset <= 1'b1;
    hold(2);
    panel_reset <= 1'b0;
    hold(2);
  endtask : press
  // with drop_start set, the start contact drops before the reset contact is cycled
  task automatic remote_clear(input logic drop_start);
    @(posedge sys_clk);
    if (drop_start) begin
      remote_start <= 1'b0;
    end
    hold(2);
    remote_reset <= 1'b1;
    hold(2);
    remote_reset <= 1'b0;
    hold(3);
  endtask : remote_clear
endmodule : far_panel_model

// ==== far_annunciator_test.sv ====
// self-checking bench for the fault annunciator
// assumes far_pkg, far_annunciator and far_panel_model
`timescale 1ns/1ps
module far_annunciator_test;
  logic                   sys_clk;
  logic                   nrst;
  logic                   clk_en;
  far_pkg::far_bus_type   bus;
  logic            [31:0] rdata;
  logic             [2:0] mode_sel;
  logic                   panel_reset, remote_reset, remote_start, sleep_req;
  logic            [15:0] warn_cond, shut_cond;
  logic            [11:0] supply;
  far_pkg::far_lamps_type lamps;
  logic                   engine_run, breaker_trip, standby, disc, exc_pwm, gov_pwm;
  logic             [7:0] duty_ind, disp_char;
  logic             [4:0] disp_pos;
  logic                   disp_we, irq;
  int                     fails, n_tests, cycles;

  far_annunciator #(.FLASH_CYC(4)) u_far_annunciator (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .bus(bus), .rdata_ff(rdata),
    .mode_sel(mode_sel), .panel_reset(panel_reset), .remote_reset(remote_reset),
    .remote_start(remote_start), .sleep_req(sleep_req), .warn_cond(warn_cond),
    .shut_cond(shut_cond), .permanent_magnet_supply(supply), .lamps_ff(lamps),
    .engine_run_ff(engine_run), .breaker_trip_ff(breaker_trip), .standby_ff(standby),
    .start_disconnect_indicator_ff(disc), .exc_pwm_ff(exc_pwm), .gov_pwm_ff(gov_pwm),
    .duty_cycle_indicator_ff(duty_ind), .disp_char_ff(disp_char),
    .disp_pos_ff(disp_pos), .disp_we_ff(disp_we), .irq_ff(irq));

  far_panel_model u_far_panel_model (
    .sys_clk(sys_clk), .mode_sel(mode_sel), .panel_reset(panel_reset),
    .remote_reset(remote_reset), .remote_start(remote_start));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask : rd

  task automatic t_warn_irq();
    rd(far_pkg::ADR_MASK, {28'h0, far_pkg::MASK_RST});
    rd(4'hf, far_pkg::RD_UNMAPPED);
    @(posedge sys_clk);
    warn_cond <= 16'h0004;
    tk(2);
    chk(lamps.warning, 1'b1);
    chk(irq, 1'b0);
    u_far_panel_model.press();
    tk(1);
    chk(lamps.warning, 1'b1);
    @(posedge sys_clk);
    warn_cond <= 16'h0000;
    wr(far_pkg::ADR_MASK, 32'h0000_0001);
    tk(2);
    chk(irq, 1'b1);
    rd(far_pkg::ADR_STATUS, 32'h0000_0001);
    wr(far_pkg::ADR_STATUS, 32'h0000_0001);
    tk(2);
    chk(irq, 1'b0);
    chk(lamps.warning, 1'b1);
    u_far_panel_model.press();
    tk(1);
    chk(lamps.warning, 1'b0);
  endtask : t_warn_irq

  task automatic t_shut_local();
    @(posedge sys_clk);
    shut_cond <= 16'h0008;
    sleep_req <= 1'b1;
    @(posedge sys_clk);
    shut_cond <= 16'h0000;
    tk(3);
    chk(lamps.shutdown, 1'b1);
    chk(breaker_trip, 1'b1);
    chk(engine_run, 1'b0);
    chk(standby, 1'b0);
    rd(far_pkg::ADR_FAULTS, 32'h0008_0000);
    rd(far_pkg::ADR_STATE, 32'h0000_000e);
    u_far_panel_model.press();
    tk(1);
    chk(lamps.shutdown, 1'b1);
    u_far_panel_model.set_inputs(far_pkg::MODE_OFF, 1'b0, 1'b0);
    u_far_panel_model.press();
    tk(1);
    chk(lamps.shutdown, 1'b0);
    chk(breaker_trip, 1'b0);
    chk(standby, 1'b1);
  endtask : t_shut_local

  task automatic t_flash();
    logic prev;
    int   n;
    n    = 0;
    prev = lamps.non_auto;
    repeat (40) begin
      tk(1);
      if (lamps.non_auto !== prev) n++;
      prev = lamps.non_auto;
    end
    // half period of 4 cycles: 10 changes in 40
    chk(n, 10);
  endtask : t_flash

  task automatic fault(input logic [15:0] s, input logic [15:0] w);
    @(posedge sys_clk);
    shut_cond <= s;
    warn_cond <= w;
    @(posedge sys_clk);
    shut_cond <= 16'h0000;
    warn_cond <= 16'h0000;
    tk(3);
  endtask : fault

  task automatic t_remote();
    u_far_panel_model.set_inputs(far_pkg::MODE_AUTO, 1'b1, 1'b0);
    fault(16'h0008, 16'h0010);
    u_far_panel_model.remote_clear(1'b0);
    tk(1);
    chk(lamps.shutdown, 1'b1);
    u_far_panel_model.remote_clear(1'b1);
    tk(1);
    chk(lamps.shutdown, 1'b0);
    chk(lamps.warning, 1'b0);
    u_far_panel_model.set_inputs(far_pkg::MODE_AUTO, 1'b0, 1'b1);
    fault(16'h0008, 16'h0000);
    chk(lamps.shutdown, 1'b1);
    u_far_panel_model.set_inputs(far_pkg::MODE_AUTO, 1'b0, 1'b0);
    tk(3);
    chk(lamps.shutdown, 1'b0);
    fault(16'h0001, 16'h0000);
    u_far_panel_model.remote_clear(1'b1);
    tk(1);
    chk(lamps.shutdown, 1'b1);
    u_far_panel_model.set_inputs(far_pkg::MODE_OFF, 1'b0, 1'b0);
    u_far_panel_model.press();
    tk(1);
    chk(lamps.shutdown, 1'b0);
  endtask : t_remote

  task automatic t_disc();
    @(posedge sys_clk);
    supply <= far_pkg::DISC_THRESH_VRMS;
    tk(3);
    chk(disc, 1'b0);
    rd(far_pkg::ADR_THRESH, {20'h0, far_pkg::DISC_THRESH_VRMS});
    @(posedge sys_clk);
    supply <= far_pkg::DISC_THRESH_VRMS + 12'h001;
    tk(3);
    chk(disc, 1'b1);
    // clock enable low freezes the indicator
    @(posedge sys_clk);
    clk_en <= 1'b0;
    supply <= far_pkg::DISC_THRESH_VRMS;
    tk(3);
    chk(disc, 1'b1);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    tk(2);
    chk(disc, 1'b0);
  endtask : t_disc

  // one full period of highs equals the applied duty
  task automatic count_pwm(output int ne, output int ng);
    ne = 0;
    ng = 0;
    repeat (100) begin
      tk(1);
      if (exc_pwm === 1'b1) ne++;
      if (gov_pwm === 1'b1) ng++;
    end
  endtask : count_pwm

  task automatic t_pwm();
    int ne;
    int ng;
    count_pwm(ne, ng);
    chk(ng, far_pkg::GOV_TYP_PCT);
    wr(far_pkg::ADR_PWM, 32'h0000_6464);
    tk(250);
    count_pwm(ne, ng);
    chk(ne, far_pkg::EXC_MAX_PCT);
    chk(ng, far_pkg::GOV_MAX_PCT);
    chk(duty_ind, far_pkg::EXC_MAX_PCT);
  endtask : t_pwm

  task automatic t_disp();
    logic [4:0] pos;
    logic [7:0] ch;
    logic       found;
    for (int i = 0; i < 2; i++) begin
      pos   = i ? 5'h1f : 5'h05;
      ch    = i ? 8'h5a : 8'h41;
      found = 1'b0;
      wr(far_pkg::ADR_DISP, {19'h0, pos, ch});
      repeat (70) begin
        tk(1);
        if (disp_we === 1'b1 && disp_pos === pos && !found) begin
          found = 1'b1;
          chk(disp_char, ch);
        end
      end
      chk(found, 1'b1);
    end
  endtask : t_disp

  initial begin
    nrst      = 1'b0;
    clk_en    = 1'b1;
    bus       = '0;
    sleep_req = 1'b0;
    warn_cond = 16'h0000;
    shut_cond = 16'h0000;
    supply    = 12'h000;
    fails     = 0;
    n_tests   = 0;
    cycles    = 0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    tk(1);
    chk(lamps.shutdown, 1'b0);
    t_warn_irq();
    t_shut_local();
    t_flash();
    t_remote();
    t_disc();
    t_pwm();
    t_disp();
    test_done();
  end
endmodule : far_annunciator_test
